// [logic/ssps_pkg.sv]
// constants and types shared by the sleep-state power sequencer
package ssps_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned RTC_HZ        = 32_768;
	localparam int unsigned OVR_SECONDS   = 4;
	// rtc tick divider: system clocks per rtc period, rounded down
	localparam int unsigned RTC_DIV       = CLK_HZ / RTC_HZ;
	localparam int unsigned OVR_RTC_TICKS = OVR_SECONDS * RTC_HZ;
	localparam int unsigned DEB_TICKS     = 4;
	localparam int unsigned WARN_LEAD     = 2;
	localparam logic [1:0]  RST_SYNC_ONE  = 2'h3;

	typedef enum logic [2:0] {
		SSPS_S0      = 3'h0,
		SSPS_WARN    = 3'h1,
		SSPS_S3      = 3'h2,
		SSPS_S45     = 3'h3,
		SSPS_WAKE    = 3'h4
	} ssps_state_e;

	typedef enum logic [1:0] {
		SSPS_TGT_S1 = 2'h0,
		SSPS_TGT_S3 = 2'h1,
		SSPS_TGT_S4 = 2'h2,
		SSPS_TGT_S5 = 2'h3
	} ssps_target_e;
endpackage : ssps_pkg

// [logic/ssps_top.sv]
// sleep-state power sequencer: sleep planes, suspend warning and power button
//
// Overview of operation
// - A low thermal alarm puts the block in clock throttling mode.
// - A thermal alarm also raises the management or control interrupt as configured, unless a same-cycle button press in S0 sets the route.
// - The ram-sleep plane control asserts on entry to S3, S4 or S5.
// - The soft-off plane control asserts only while in S4 or S5.
// - The bus reset asserts whenever core power good is low.
// - A button press while awake raises an interrupt asking for sleep.
// - A button press while asleep is a wake event.
// - Holding the button over four seconds outside S4 or S5 forces S5 with only the button as wake source.
// - Ring indicate is an enableable wake source whose enable lives in the resume well.
// - The resume-well reset clears all resume-plane logic.
// - The suspend warning asserts shortly before a requested low-power state; an override from S0 asserts it with the planes.
// - The suspend refresh clock is output from the rtc divider.
`timescale 1ns/10ps
module ssps_top import ssps_pkg::*; #(
	parameter int unsigned OVR_TICKS = OVR_RTC_TICKS,
	parameter int unsigned DIV       = RTC_DIV
) (
	input  wire logic       CLK_I,
	input  wire logic       RESETN_I,
	input  wire logic       CE_I,
	input  wire logic       THERMAL_ALARM_N_I,
	input  wire logic       THERM_TO_SCI_I,
	input  wire logic       POWER_BUTTON_N_I,
	input  wire logic       RING_INDICATE_N_I,
	input  wire logic       RING_WAKE_EN_I,
	input  wire logic       RING_WAKE_EN_LOAD_I,
	input  wire logic       CORE_POWER_GOOD_I,
	input  wire logic       REGULATOR_POWER_GOOD_I,
	input  wire logic       NETWORK_CTRL_RESET_N_I,
	input  wire logic       SLEEP_REQ_I,
	input  wire logic [1:0] SLEEP_TYPE_I,
	input  wire logic       BTN_TO_SCI_I,
	output logic            THROTTLE_O,
	output logic            SYSTEM_MGMT_INTERRUPT_N_O,
	output logic            ACPI_CONTROL_INTERRUPT_O,
	output logic            RAM_SLEEP_PLANE_CTL_N_O,
	output logic            SOFT_OFF_PLANE_CTL_N_O,
	output logic            HOST_BUS_RESET_N_O,
	output logic            SUSPEND_WARNING_N_O,
	output logic            SUSPEND_REFRESH_CLOCK_O,
	output logic            WAKE_EVENT_O,
	output logic            OVERRIDE_O,
	output logic [2:0]      STATE_O
);
	localparam int DW = $clog2(DIV + 1);
	localparam int OW = $clog2(OVR_TICKS + 2);
	localparam int BW = $clog2(DEB_TICKS + 1);
	localparam int WW = $clog2(WARN_LEAD + 1);

	typedef struct packed {
		logic [DW-1:0] div;
		logic          sclk;
		logic [1:0]    btn_sync;
		logic [BW-1:0] deb_cnt;
		logic          btn;
		logic [OW-1:0] hold;
		logic          ovr_done;
		logic          therm_q;
		logic          smi;
		logic          acpi_control_interrupt;
		logic          ri_en;
		logic          btn_only;
		logic [WW-1:0] warn_cnt;
		ssps_target_e  tgt;
		ssps_state_e   st;
		logic          wake;
		logic          s3_n;
		logic          s5_n;
		logic          warn_n;
	} ssps_s;

	ssps_s s_q, s_d;
	logic  tick;
	logic  press_edge;

	function automatic logic deep(input ssps_target_e t);
		return (t == SSPS_TGT_S4) || (t == SSPS_TGT_S5);
	endfunction : deep

	assign tick       = (s_q.div == DW'(DIV - 1));
	always_comb begin
		s_d        = s_q;
		press_edge = 1'b0;
		s_d.wake   = 1'b0;
		s_d.smi    = 1'b0;
		s_d.acpi_control_interrupt    = 1'b0;
		// rtc-rate tick also toggles the refresh clock
		if (tick) begin
			s_d.div  = '0;
			s_d.sclk = ~s_q.sclk;
		end else begin
			s_d.div = s_q.div + DW'(1);
		end
		s_d.btn_sync = {s_q.btn_sync[0], ~POWER_BUTTON_N_I};
		if (tick) begin
			// debounce: level must persist for several rtc ticks
			if (s_q.btn_sync[1] == s_q.btn) begin
				s_d.deb_cnt = '0;
			end else if (s_q.deb_cnt == BW'(DEB_TICKS - 1)) begin
				s_d.deb_cnt = '0;
				s_d.btn     = s_q.btn_sync[1];
				press_edge  = s_q.btn_sync[1];
			end else begin
				s_d.deb_cnt = s_q.deb_cnt + BW'(1);
			end
			if (s_q.btn && !s_q.ovr_done) begin
				s_d.hold = s_q.hold + OW'(1);
				if (s_q.hold == OW'(OVR_TICKS)) begin
					s_d.ovr_done = 1'b1;
				end
			end
		end
		if (!s_q.btn) begin
			s_d.hold     = '0;
			s_d.ovr_done = 1'b0;
		end
		s_d.therm_q = ~THERMAL_ALARM_N_I;
		if (!THERMAL_ALARM_N_I && !s_q.therm_q) begin
			s_d.acpi_control_interrupt = THERM_TO_SCI_I;
			s_d.smi = ~THERM_TO_SCI_I;
		end
		if (RING_WAKE_EN_LOAD_I) begin
			s_d.ri_en = RING_WAKE_EN_I;
		end
		unique case (s_q.st)
			SSPS_S0: begin
				if (press_edge) begin
					s_d.acpi_control_interrupt = BTN_TO_SCI_I;
					s_d.smi = ~BTN_TO_SCI_I;
				end
				if (SLEEP_REQ_I && SLEEP_TYPE_I != SSPS_TGT_S1) begin
					s_d.tgt      = ssps_target_e'(SLEEP_TYPE_I);
					s_d.warn_n   = 1'b0;
					s_d.warn_cnt = '0;
					s_d.st       = SSPS_WARN;
				end
			end
			SSPS_WARN: begin
				s_d.warn_cnt = s_q.warn_cnt + WW'(1);
				if (s_q.warn_cnt == WW'(WARN_LEAD - 1)) begin
					s_d.s3_n = 1'b0;
					s_d.st   = deep(s_q.tgt) ? SSPS_S45 : SSPS_S3;
					s_d.s5_n = ~deep(s_q.tgt);
				end
			end
			SSPS_S3, SSPS_S45: begin
				if (press_edge || (s_q.ri_en && !RING_INDICATE_N_I && !s_q.btn_only)) begin
					s_d.wake = 1'b1;
					s_d.s3_n = 1'b1;
					s_d.s5_n = 1'b1;
					s_d.st   = SSPS_WAKE;
				end
			end
			SSPS_WAKE: begin
				s_d.warn_n   = 1'b1;
				s_d.btn_only = 1'b0;
				s_d.st       = SSPS_S0;
			end
			default: s_d.st = SSPS_S0;
		endcase
		// override wins over any state except SSPS_S45, even light sleep
		if (s_q.ovr_done && !s_q.btn_only && s_q.st != SSPS_S45) begin
			s_d.tgt      = SSPS_TGT_S5;
			s_d.warn_n   = 1'b0;
			s_d.s3_n     = 1'b0;
			s_d.s5_n     = 1'b0;
			s_d.btn_only = 1'b1;
			s_d.st       = SSPS_S45;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			s_q        <= '0;
			s_q.sclk   <= 1'b0;
			s_q.tgt    <= SSPS_TGT_S1;
			s_q.st     <= SSPS_S0;
			s_q.s3_n   <= 1'b1;
			s_q.s5_n   <= 1'b1;
			s_q.warn_n <= 1'b1;
		end else if (CE_I) begin
			s_q <= s_d;
		end
	end

	assign THROTTLE_O                = s_q.therm_q;
	assign SYSTEM_MGMT_INTERRUPT_N_O = ~s_q.smi;
	assign ACPI_CONTROL_INTERRUPT_O  = s_q.acpi_control_interrupt;
	assign RAM_SLEEP_PLANE_CTL_N_O   = s_q.s3_n;
	assign SOFT_OFF_PLANE_CTL_N_O    = s_q.s5_n;
	// reset follows power good directly so it holds even with the clock gated
	assign HOST_BUS_RESET_N_O        = CORE_POWER_GOOD_I & RESETN_I;
	assign SUSPEND_WARNING_N_O       = s_q.warn_n;
	assign SUSPEND_REFRESH_CLOCK_O   = s_q.sclk;
	assign WAKE_EVENT_O              = s_q.wake;
	assign OVERRIDE_O                = s_q.btn_only;
	assign STATE_O                   = s_q.st;

	a_s5_implies_s3: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!SOFT_OFF_PLANE_CTL_N_O |-> !RAM_SLEEP_PLANE_CTL_N_O) else $error("s5 without s3");
	a_s5_only_deep: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!SOFT_OFF_PLANE_CTL_N_O |-> s_q.st == SSPS_S45) else $error("s5 outside deep sleep");
	a_bus_reset: assert property (@(posedge CLK_I)
		!CORE_POWER_GOOD_I |-> !HOST_BUS_RESET_N_O) else $error("bus reset missing");
	a_warn_first: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!RAM_SLEEP_PLANE_CTL_N_O |-> !SUSPEND_WARNING_N_O) else $error("plane before warning");
	sequence warn_start;
		CE_I && $fell(SUSPEND_WARNING_N_O) && s_q.st == SSPS_WARN;
	endsequence
	a_warn_lead: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		warn_start |-> RAM_SLEEP_PLANE_CTL_N_O) else $error("no warning lead");
	a_override: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(CE_I && s_q.ovr_done && !s_q.btn_only && s_q.st != SSPS_S45) |=> OVERRIDE_O && !SOFT_OFF_PLANE_CTL_N_O)
		else $error("override not taken");
	a_throttle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		CE_I && !THERMAL_ALARM_N_I |=> THROTTLE_O) else $error("no throttle");
	a_therm_irq: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		CE_I && !THERMAL_ALARM_N_I && !s_q.therm_q && THERM_TO_SCI_I |=> ACPI_CONTROL_INTERRUPT_O)
		else $error("thermal interrupt missing");
	a_wake_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$rose(SUSPEND_WARNING_N_O) |-> RAM_SLEEP_PLANE_CTL_N_O && SOFT_OFF_PLANE_CTL_N_O)
		else $error("warning released early");
endmodule : ssps_top

// [testbench/ssps_board.sv]
// board model: supplies, network reset and core power good
`timescale 1ns/10ps
module ssps_board #(
	parameter int unsigned DIV = 4
) (
	input  wire logic clk_i,
	input  wire logic drop_i,
	output logic      power_good_o,
	output logic      regulator_good_o,
	output logic      network_reset_n_o
);
	int unsigned up_q  = 0;
	int unsigned low_q = 0;
	// one driver per output: start values live in the registers
	logic        pg_q  = 1'b0;
	logic        vg_q  = 1'b0;
	logic        nr_q  = 1'b0;
	assign power_good_o      = pg_q;
	assign regulator_good_o  = vg_q;
	assign network_reset_n_o = nr_q;
	always @(posedge clk_i) begin
		if (up_q < 40)
			up_q <= up_q + 1;
		vg_q <= (up_q >= 5);
		nr_q <= (up_q >= 15);
		if (drop_i)
			low_q <= 0;
		else if (low_q < 3 * DIV + 2)
			low_q <= low_q + 1;
		// scaled stable time before good, low held past three rtc periods
		pg_q <= (up_q >= 30) && (low_q > 3 * DIV);
	end
endmodule : ssps_board

// [testbench/ssps_top_test.sv]
// self-checking bench for the sleep-state power sequencer
`timescale 1ns/10ps
module ssps_top_test import ssps_pkg::*;;
	logic clk=0, rst_n=0, alm_n=1, th_sci=0, btn_n=1, ri_n=1, ri_en=0, ri_ld=0;
	logic pg, vg, nr_n, req=0, b_sci=0, drop=0, ce=1;
	logic [1:0] typ=2'h0;
	logic thr, smi_n, acpi_control_interrupt, s3_n, s5_n, brst_n, warn_n, sclk, wake, ovr;
	logic [2:0] st;
	int fail_count=0, checked=0, n;
	ssps_board #(.DIV(4)) i_ssps_board (.clk_i(clk), .drop_i(drop), .power_good_o(pg),
		.regulator_good_o(vg), .network_reset_n_o(nr_n));
	ssps_top #(.OVR_TICKS(8), .DIV(4)) i_ssps_top (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce),
		.THERMAL_ALARM_N_I(alm_n), .THERM_TO_SCI_I(th_sci), .POWER_BUTTON_N_I(btn_n),
		.RING_INDICATE_N_I(ri_n), .RING_WAKE_EN_I(ri_en), .RING_WAKE_EN_LOAD_I(ri_ld),
		.CORE_POWER_GOOD_I(pg), .REGULATOR_POWER_GOOD_I(vg), .NETWORK_CTRL_RESET_N_I(nr_n),
		.SLEEP_REQ_I(req), .SLEEP_TYPE_I(typ), .BTN_TO_SCI_I(b_sci), .THROTTLE_O(thr),
		.SYSTEM_MGMT_INTERRUPT_N_O(smi_n), .ACPI_CONTROL_INTERRUPT_O(acpi_control_interrupt),
		.RAM_SLEEP_PLANE_CTL_N_O(s3_n), .SOFT_OFF_PLANE_CTL_N_O(s5_n), .HOST_BUS_RESET_N_O(brst_n),
		.SUSPEND_WARNING_N_O(warn_n), .SUSPEND_REFRESH_CLOCK_O(sclk), .WAKE_EVENT_O(wake),
		.OVERRIDE_O(ovr), .STATE_O(st));
	initial forever #5 clk = ~clk;
	task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	// button or alarm interrupt; route picks smi (0) or acpi (1)
	task irq_route(input logic r, input logic by_btn);
		th_sci = r;
		b_sci = r;
		if (by_btn) btn_n = 0; else alm_n = 0;
		for (n = 0; n < 60 && smi_n !== 1'b0 && acpi_control_interrupt !== 1'b1; n++) cyc(1);
		chk("route", {3'h0, acpi_control_interrupt}, {3'h0, r});
		chk("smi", {3'h0, smi_n}, {3'h0, r});
		cyc(2);
		if (!by_btn) chk("throttle", {3'h0, thr}, 4'h1);
		btn_n = 1;
		alm_n = 1;
		cyc(30);
		chk("state", {1'b0, st}, 4'h0);
	endtask : irq_route
	task go_sleep(input logic [1:0] t);
		typ = t;
		req = 1;
		cyc(1);
		req = 0;
		for (n = 0; n < 6 && warn_n !== 1'b0; n++) cyc(1);
		chk("warn", {3'h0, warn_n}, 4'h0);
		chk("ram early", {3'h0, s3_n}, 4'h1);
		cyc(4);
		chk("ram", {3'h0, s3_n}, 4'h0);
		chk("soft", {3'h0, s5_n}, {3'h0, t == 2'h1});
		chk("st", {1'b0, st}, t == 2'h1 ? 4'h2 : 4'h3);
	endtask : go_sleep
	task wake_by(input logic ring);
		if (ring) ri_n = 0; else btn_n = 0;
		for (n = 0; n < 80 && wake !== 1'b1; n++) cyc(1);
		chk("wake", {3'h0, wake}, 4'h1);
		chk("planes", {2'h0, s3_n, s5_n}, 4'h3);
		chk("warn hold", {3'h0, warn_n}, 4'h0);
		btn_n = 1;
		ri_n = 1;
		cyc(30);
		chk("warn off", {3'h0, warn_n}, 4'h1);
	endtask : wake_by
	task t_sleep;
		for (int t = 1; t < 4; t++) begin
			go_sleep(t[1:0]);
			wake_by(0);
		end
		typ = 2'h0;
		req = 1;
		cyc(1);
		req = 0;
		cyc(5);
		chk("s1 ignored", {3'h0, warn_n}, 4'h1);
		ri_en = 1;
		ri_ld = 1;
		cyc(1);
		ri_ld = 0;
		go_sleep(2'h2);
		wake_by(1);
		$display("sleep and wake done");
	endtask : t_sleep
	task t_override;
		go_sleep(2'h1);
		btn_n = 0;
		for (n = 0; n < 300 && ovr !== 1'b1; n++) cyc(1);
		chk("override", {1'b0, ovr, s3_n, s5_n}, 4'h4);
		chk("ovr st", {1'b0, st}, 4'h3);
		btn_n = 1;
		cyc(30);
		ri_n = 0;
		for (n = 0; n < 30 && wake !== 1'b1; n++) cyc(1);
		chk("ring ignored", {3'h0, wake}, 4'h0);
		ri_n = 1;
		wake_by(0);
		go_sleep(2'h3);
		rst_n = 0;
		cyc(4);
		chk("reset", {ovr, s3_n, s5_n, warn_n}, 4'h7);
		rst_n = 1;
		cyc(1);
		chk("reset st", {1'b0, st}, 4'h0);
		$display("override done");
	endtask : t_override
	task t_power;
		drop = 1;
		cyc(2);
		chk("bus reset", {3'h0, brst_n}, 4'h0);
		drop = 0;
		for (n = 0; n < 40 && pg !== 1'b1; n++) cyc(1);
		chk("bus run", {3'h0, brst_n}, 4'h1);
		// align to a full high phase, whatever phase we arrive in
		for (n = 0; n < 20 && sclk === 1'b1; n++) cyc(1);
		for (n = 0; n < 20 && sclk === 1'b0; n++) cyc(1);
		for (n = 0; n < 20 && sclk === 1'b1; n++) cyc(1);
		chk("clk half", n[3:0], 4'h4);
		$display("power and clock done");
	endtask : t_power
	task t_freeze;
		logic s;
		s = sclk;
		ce = 0;
		cyc(12);
		chk("freeze clk", {3'h0, sclk}, {3'h0, s});
		chk("freeze st", {1'b0, st}, 4'h0);
		ce = 1;
		cyc(2);
		$display("freeze done");
	endtask : t_freeze
	initial begin
		#200us;
		fail_count++;
		wrap_up();
	end
	initial begin
		cyc(4);
		rst_n = 1;
		cyc(40);
		for (int r = 0; r < 4; r++) irq_route(r[0], r[1]);
		$display("interrupts done");
		t_sleep();
		t_override();
		t_power();
		t_freeze();
		wrap_up();
	end
endmodule : ssps_top_test
